// ===== inc/serial_port_pkg.sv
// constants and types shared by the addressable serial port design
`default_nettype none
package serial_port_pkg;
  // register byte addresses on the APB
  localparam logic [7:0] ADDR_TXCTL = 8'h00;
  localparam logic [7:0] ADDR_RXCTL = 8'h04;
  localparam logic [7:0] ADDR_BAUD = 8'h08;
  localparam logic [7:0] ADDR_TXDATA = 8'h0C;
  localparam logic [7:0] ADDR_RXDATA = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  // transmit control field positions
  localparam int TX_CLKSRC = 7;
  localparam int TX_NINE = 6;
  localparam int TX_EN = 5;
  localparam int TX_SYNC = 4;
  localparam int TX_UNUSED = 3;
  localparam int TX_HIGH = 2;
  localparam int TX_EMPTY = 1;
  localparam int TX_NINTH = 0;
  // receive control field positions
  localparam int RX_PORT = 7;
  localparam int RX_NINE = 6;
  localparam int RX_SINGLE = 5;
  localparam int RX_CONT = 4;
  localparam int RX_ADDR = 3;
  // writable masks and read-only bit images
  localparam logic [7:0] TXCTL_WMASK = 8'hF5;
  localparam logic [7:0] RXCTL_WMASK = 8'hF8;
  localparam logic [7:0] TXCTL_EMPTY_BIT = 8'h02;
  localparam logic [7:0] RXCTL_FRAMING_ERROR_FLAG_BIT = 8'h04;
  localparam logic [7:0] RXCTL_OVERRUN_ERROR_FLAG_BIT = 8'h02;
  localparam logic [7:0] RXCTL_NINTH_BIT = 8'h01;
  // reset values
  localparam logic [7:0] TXCTL_RESET = 8'h00;
  localparam logic [7:0] RXCTL_RESET = 8'h00;
  localparam logic [7:0] BAUD_RESET = 8'h00;
  // baud ticks per bit for each mode
  localparam logic [6:0] TICKS_ASYNC_LOW = 7'h40;
  localparam logic [6:0] TICKS_ASYNC_HIGH = 7'h10;
  localparam logic [6:0] TICKS_SYNC = 7'h04;
  // word lengths
  localparam logic [3:0] BITS_8 = 4'h8;
  localparam logic [3:0] BITS_9 = 4'h9;
  // serial line sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_START = 2'b01,
    ST_DATA = 2'b10,
    ST_STOP = 2'b11
  } line_state_t;
  // one completed received word
  typedef struct packed {
    logic [7:0] data;
    logic ninth;
    logic stop_ok;
  } rx_word_t;
endpackage
`default_nettype wire

// ===== verilog/serial_port_ctrl.sv
// control, status, baud generator and line sequencers of the addressable serial port
`default_nettype none
// Behaviour
// R1 - sync mode: clock source bit set means master clock, clear means slave
// R2 - transmit nine bits when nine-bit transmit select set, else eight
// R3 - transmit enable gates transmitter; sync receive enables override it
// R4 - mode select bit set gives synchronous, clear gives asynchronous operation
// R5 - high baud select picks divide-by-16 versus 64, async only
// R6 - shift register empty bit reads 1 when idle, resets to 1
// R7 - transmit ninth bit supplies bit nine of a nine-bit word
// R8 - port enable hands pins to the port; clear holds port in reset
// R9 - receive nine bits when nine-bit receive select set, else eight
// R10 - single receive starts one sync-master reception, cleared when done
// R11 - continuous receive switches receiver; in sync overrides single receive
// R12 - async nine-bit with address detect keeps only words with ninth bit 1
// R13 - framing error flag set on bad stop, updated by next loaded word
// R14 - overrun flag set on overrun, held until continuous receive cleared
// R15 - received ninth bit shown unchanged, no parity computed
// R16 - dedicated 8-bit free-running baud timer, period from divisor register
// R17 - any divisor write clears the baud timer at once
// R18 - bit rate is clock over 64, 16 or 4 times (n+1)
// R19 - receive level is majority of three samples per bit
// R20 - unused transmit control bit ignores writes and reads zero
// R21 - pin directions follow mode and operation automatically
// R22 - async frame: low start, data LSB first, high stop; low stop errs
module serial_port_ctrl (
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic TXCK_PIN_IN,
  output logic TXCK_PIN_OUT,
  output logic TXCK_PIN_OE,
  input wire logic RXDT_PIN_IN,
  output logic RXDT_PIN_OUT,
  output logic RXDT_PIN_OE
);
  // baud ticks per bit for the current mode
  function automatic logic [6:0] ticks_per_bit(input logic is_sync, input logic high);
    if (is_sync) begin
      return serial_port_pkg::TICKS_SYNC;
    end else if (high) begin
      return serial_port_pkg::TICKS_ASYNC_HIGH;
    end else begin
      return serial_port_pkg::TICKS_ASYNC_LOW;
    end
  endfunction

  // two-of-three vote
  function automatic logic maj3(input logic [2:0] s);
    return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  logic [7:0] txctl_r, rxctl_r, baud_r, baud_cnt_r, txbuf_r, rxbuf_r;
  logic txbuf_full_r, rxbuf_full_r, rxrd_full_r, framing_error_flag_r, overrun_error_flag_r, ninth_rx_r;
  logic pready_r, pslverr_r;
  logic [31:0] prdata_r;
  logic [2:0] rxh_r;
  logic [1:0] ck_hist_r;
  serial_port_pkg::line_state_t tx_st_r, rx_st_r;
  logic [8:0] tx_sh_r, rx_sh_r;
  logic [3:0] tx_cnt_r, rx_cnt_r;
  logic [6:0] tx_ph_r, rx_ph_r;
  logic tx_out_r, txck_out_r, txck_oe_r, rxdt_out_r, rxdt_oe_r;

  // apb decode
  wire setup = PSEL & ~PENABLE;
  wire access = PSEL & PENABLE & pready_r;
  wire wr_en = access & PWRITE;
  wire rd_en = access & ~PWRITE;
  wire hit_txctl = PADDR == serial_port_pkg::ADDR_TXCTL;
  wire hit_rxctl = PADDR == serial_port_pkg::ADDR_RXCTL;
  wire hit_baud = PADDR == serial_port_pkg::ADDR_BAUD;
  wire hit_txdata = PADDR == serial_port_pkg::ADDR_TXDATA;
  wire hit_rxdata = PADDR == serial_port_pkg::ADDR_RXDATA;
  wire hit_status = PADDR == serial_port_pkg::ADDR_STATUS;
  wire mapped = hit_txctl | hit_rxctl | hit_baud | hit_txdata | hit_rxdata | hit_status;
  wire wr_baud = wr_en & hit_baud;
  wire wr_rxctl = wr_en & hit_rxctl;

  // mode decode
  wire port_enable = rxctl_r[serial_port_pkg::RX_PORT];
  wire sync = txctl_r[serial_port_pkg::TX_SYNC]; // [R4]
  wire master = sync & txctl_r[serial_port_pkg::TX_CLKSRC]; // [R1]
  wire slave = sync & ~txctl_r[serial_port_pkg::TX_CLKSRC]; // [R1]
  wire nine_rx = rxctl_r[serial_port_pkg::RX_NINE];
  wire cont_rx = rxctl_r[serial_port_pkg::RX_CONT];
  wire single_rx = rxctl_r[serial_port_pkg::RX_SINGLE];
  // single receive counts only for a sync master; continuous wins
  wire rx_on = cont_rx | (master & single_rx); // [R10] [R11]
  wire rx_run = port_enable & rx_on & ~overrun_error_flag_r;
  wire sync_rx = sync & rx_on;
  wire tx_allow = port_enable & txctl_r[serial_port_pkg::TX_EN] & ~sync_rx; // [R3]
  wire [6:0] k = ticks_per_bit(sync, txctl_r[serial_port_pkg::TX_HIGH]); // [R5] [R18]
  wire [6:0] k_last = k - 7'h01;
  wire [6:0] k_half = k >> 1;

  // register views
  wire tx_busy = tx_st_r != serial_port_pkg::ST_IDLE;
  wire rx_busy = rx_st_r != serial_port_pkg::ST_IDLE;
  wire [7:0] txctl_view = txctl_r | (tx_busy ? 8'h00 : serial_port_pkg::TXCTL_EMPTY_BIT); // [R6]
  wire [7:0] rxctl_view = rxctl_r | (framing_error_flag_r ? serial_port_pkg::RXCTL_FRAMING_ERROR_FLAG_BIT : 8'h00)
                          | (overrun_error_flag_r ? serial_port_pkg::RXCTL_OVERRUN_ERROR_FLAG_BIT : 8'h00)
                          | (ninth_rx_r ? serial_port_pkg::RXCTL_NINTH_BIT : 8'h00);
  wire [31:0] rd_mux = hit_txctl ? {24'h000000, txctl_view}
                     : hit_rxctl ? {24'h000000, rxctl_view}
                     : hit_baud ? {24'h000000, baud_r}
                     : hit_rxdata ? {24'h000000, rxbuf_r}
                     : hit_status ? {30'h00000000, txbuf_full_r, rxbuf_full_r}
                     : 32'h00000000;

  // apb answer: ready in the cycle after setup, no wait states
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      pready_r <= 1'b0;
      prdata_r <= 32'h00000000;
      pslverr_r <= 1'b0;
      rxrd_full_r <= 1'b0;
    end else begin
      pready_r <= setup;
      prdata_r <= (setup & ~PWRITE) ? rd_mux : 32'h00000000;
      pslverr_r <= setup & ~mapped;
      // only a read that saw a full buffer may empty it, so no word is lost
      rxrd_full_r <= setup & hit_rxdata & rxbuf_full_r;
    end
  end

  // software registers; read-only and unused bits masked off on write
  wire single_receive_enable_hw_clr;
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      txctl_r <= serial_port_pkg::TXCTL_RESET;
      rxctl_r <= serial_port_pkg::RXCTL_RESET;
      baud_r <= serial_port_pkg::BAUD_RESET;
    end else begin
      if (wr_en & hit_txctl) begin
        txctl_r <= PWDATA[7:0] & serial_port_pkg::TXCTL_WMASK; // [R20]
      end
      if (wr_baud) begin
        baud_r <= PWDATA[7:0];
      end
      if (wr_rxctl) begin
        rxctl_r <= PWDATA[7:0] & serial_port_pkg::RXCTL_WMASK;
      end else if (single_receive_enable_hw_clr) begin
        rxctl_r[serial_port_pkg::RX_SINGLE] <= 1'b0; // [R10]
      end
    end
  end

  // free-running baud timer, one tick every baud_r+1 clocks
  wire tick = port_enable & (baud_cnt_r == baud_r); // [R16]
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      baud_cnt_r <= 8'h00;
    end else if (~port_enable | tick | wr_baud) begin
      baud_cnt_r <= 8'h00; // [R17] [R8]
    end else begin
      baud_cnt_r <= baud_cnt_r + 8'h01; // [R16]
    end
  end

  // pin history; inputs already synchronous, so plain sample registers
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      rxh_r <= 3'h7;
      ck_hist_r <= 2'h0;
    end else begin
      rxh_r <= {rxh_r[1:0], RXDT_PIN_IN};
      ck_hist_r <= {ck_hist_r[0], TXCK_PIN_IN};
    end
  end
  wire rx_level = maj3(rxh_r); // [R19]
  wire ck_rise = ck_hist_r == 2'h1;
  wire ck_fall = ck_hist_r == 2'h2;

  // transmit buffer; a write while full is dropped
  wire tx_load = ~tx_busy & txbuf_full_r & tx_allow;
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      txbuf_r <= 8'h00;
      txbuf_full_r <= 1'b0;
    end else if (~port_enable) begin
      txbuf_full_r <= 1'b0;
    end else if (tx_load) begin
      txbuf_full_r <= 1'b0;
    end else if (wr_en & hit_txdata & ~txbuf_full_r) begin
      txbuf_r <= PWDATA[7:0];
      txbuf_full_r <= 1'b1;
    end
  end

  // transmit sequencer; slave shifts on the peer clock falling edge
  wire tx_adv = slave ? ck_fall : (tick & (tx_ph_r == k_last));
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      tx_st_r <= serial_port_pkg::ST_IDLE;
      tx_sh_r <= 9'h000;
      tx_cnt_r <= 4'h0;
      tx_ph_r <= 7'h00;
      tx_out_r <= 1'b1;
    end else if (~port_enable | sync_rx) begin
      tx_st_r <= serial_port_pkg::ST_IDLE; // [R8] [R3]
      tx_ph_r <= 7'h00;
      tx_out_r <= 1'b1;
    end else if (tx_load) begin
      tx_sh_r <= {txctl_r[serial_port_pkg::TX_NINTH], txbuf_r}; // [R7]
      tx_cnt_r <= txctl_r[serial_port_pkg::TX_NINE] ? serial_port_pkg::BITS_9
                                                    : serial_port_pkg::BITS_8; // [R2]
      tx_ph_r <= 7'h00;
      tx_st_r <= sync ? serial_port_pkg::ST_DATA : serial_port_pkg::ST_START;
      tx_out_r <= sync ? txbuf_r[0] : 1'b0; // [R22]
    end else if (tx_busy) begin
      if (tick) begin
        tx_ph_r <= (tx_ph_r == k_last) ? 7'h00 : tx_ph_r + 7'h01;
      end
      if (tx_adv) begin
        unique case (tx_st_r)
          serial_port_pkg::ST_START: begin
            tx_st_r <= serial_port_pkg::ST_DATA;
            tx_out_r <= tx_sh_r[0]; // [R22]
          end
          serial_port_pkg::ST_DATA: begin
            tx_sh_r <= tx_sh_r >> 1;
            tx_cnt_r <= tx_cnt_r - 4'h1;
            if (tx_cnt_r == 4'h1) begin
              tx_st_r <= sync ? serial_port_pkg::ST_IDLE : serial_port_pkg::ST_STOP;
              tx_out_r <= 1'b1; // [R22]
            end else begin
              tx_out_r <= tx_sh_r[1];
            end
          end
          serial_port_pkg::ST_STOP: tx_st_r <= serial_port_pkg::ST_IDLE;
          serial_port_pkg::ST_IDLE: tx_st_r <= serial_port_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // receive sequencer; async waits for a low voted level as start
  wire rx_begin = ~rx_busy & rx_run & (sync | ~rx_level);
  wire rx_take = slave ? ck_rise : (tick & (rx_ph_r == k_half));
  wire [8:0] rx_sh_in = {rx_level, rx_sh_r[8:1]};
  wire rx_last = (rx_st_r == serial_port_pkg::ST_DATA) & (rx_cnt_r == 4'h1);
  wire rx_done = rx_take & ((rx_st_r == serial_port_pkg::ST_STOP) | (rx_last & sync));
  wire [8:0] rx_bits = sync ? rx_sh_in : rx_sh_r;
  serial_port_pkg::rx_word_t rx_word;
  assign rx_word = {nine_rx ? rx_bits[7:0] : rx_bits[8:1], nine_rx & rx_bits[8],
                    sync | rx_level}; // [R9] [R22]
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      rx_st_r <= serial_port_pkg::ST_IDLE;
      rx_sh_r <= 9'h000;
      rx_cnt_r <= 4'h0;
      rx_ph_r <= 7'h00;
    end else if (~rx_run) begin
      rx_st_r <= serial_port_pkg::ST_IDLE; // [R8] [R11]
      rx_ph_r <= 7'h00;
    end else if (rx_begin) begin
      rx_st_r <= sync ? serial_port_pkg::ST_DATA : serial_port_pkg::ST_START;
      rx_cnt_r <= nine_rx ? serial_port_pkg::BITS_9 : serial_port_pkg::BITS_8; // [R9]
      rx_ph_r <= 7'h00;
    end else if (rx_busy) begin
      if (tick) begin
        rx_ph_r <= (rx_ph_r == k_last) ? 7'h00 : rx_ph_r + 7'h01;
      end
      if (rx_take) begin
        unique case (rx_st_r)
          serial_port_pkg::ST_START: begin
            // high at start centre is a glitch, not a word
            rx_st_r <= rx_level ? serial_port_pkg::ST_IDLE : serial_port_pkg::ST_DATA;
          end
          serial_port_pkg::ST_DATA: begin
            rx_sh_r <= rx_sh_in; // [R22]
            rx_cnt_r <= rx_cnt_r - 4'h1;
            if (rx_last) begin
              rx_st_r <= sync ? serial_port_pkg::ST_IDLE : serial_port_pkg::ST_STOP;
            end
          end
          serial_port_pkg::ST_STOP: rx_st_r <= serial_port_pkg::ST_IDLE;
          serial_port_pkg::ST_IDLE: rx_st_r <= serial_port_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // receive buffer, error flags and address filter
  wire rx_keep = ~(~sync & nine_rx & rxctl_r[serial_port_pkg::RX_ADDR] & ~rx_word.ninth); // [R12]
  wire rx_load = rx_done & rx_keep & ~rxbuf_full_r;
  wire rx_over = rx_done & rx_keep & rxbuf_full_r;
  wire rx_read = rd_en & hit_rxdata & rxrd_full_r;
  assign single_receive_enable_hw_clr = rx_done & master & single_rx & ~cont_rx; // [R10]
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      rxbuf_r <= 8'h00;
      ninth_rx_r <= 1'b0;
      framing_error_flag_r <= 1'b0;
      rxbuf_full_r <= 1'b0;
    end else if (~port_enable) begin
      rxbuf_full_r <= 1'b0; // [R8]
      framing_error_flag_r <= 1'b0;
    end else if (rx_load) begin
      rxbuf_r <= rx_word.data;
      ninth_rx_r <= rx_word.ninth; // [R15]
      framing_error_flag_r <= ~rx_word.stop_ok; // [R13]
      rxbuf_full_r <= 1'b1;
    end else if (rx_read) begin
      rxbuf_full_r <= 1'b0;
    end
  end

  // overrun is sticky: a new overrun beats the clear
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      overrun_error_flag_r <= 1'b0;
    end else if (~port_enable) begin
      overrun_error_flag_r <= 1'b0;
    end else if (rx_over) begin
      overrun_error_flag_r <= 1'b1; // [R14]
    end else if (~cont_rx) begin
      overrun_error_flag_r <= 1'b0; // [R14]
    end
  end

  // pin drivers; master clock high in the second half of each bit
  wire [6:0] act_ph = rx_busy ? rx_ph_r : tx_ph_r;
  wire ck_drive = master & (tx_busy | rx_busy) & (act_ph >= k_half); // [R1]
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      txck_oe_r <= 1'b0;
      txck_out_r <= 1'b1;
      rxdt_oe_r <= 1'b0;
      rxdt_out_r <= 1'b1;
    end else begin
      txck_oe_r <= port_enable & (sync ? master : txctl_r[serial_port_pkg::TX_EN]); // [R21] [R8]
      txck_out_r <= sync ? ck_drive : tx_out_r;
      rxdt_oe_r <= port_enable & sync & tx_busy; // [R21]
      rxdt_out_r <= tx_out_r;
    end
  end

  assign PRDATA = prdata_r;
  assign PREADY = pready_r;
  assign PSLVERR = pslverr_r;
  assign TXCK_PIN_OUT = txck_out_r;
  assign TXCK_PIN_OE = txck_oe_r;
  assign RXDT_PIN_OUT = rxdt_out_r;
  assign RXDT_PIN_OE = rxdt_oe_r;

  // checks
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_B);

  property p_disable_reset;
    !port_enable |=> !tx_busy && !rx_busy && !overrun_error_flag_r && !rxbuf_full_r && !txbuf_full_r;
  endproperty
  a_disable_reset: assert property (p_disable_reset) else $error("port not held in reset"); // [R8]

  property p_baud_restart;
    wr_baud ##1 port_enable |-> baud_cnt_r == 8'h00 ##1 (baud_cnt_r == 8'h01 || tick || wr_baud);
  endproperty
  a_baud_restart: assert property (p_baud_restart) else $error("baud timer not cleared"); // [R17]

  property p_baud_bound;
    port_enable |-> baud_cnt_r <= baud_r;
  endproperty
  a_baud_bound: assert property (p_baud_bound) else $error("baud timer past divisor"); // [R16]

  property p_start_low;
    tx_load && !sync |=> tx_st_r == serial_port_pkg::ST_START && !tx_out_r;
  endproperty
  a_start_low: assert property (p_start_low) else $error("start bit not low"); // [R22]

  property p_stop_high;
    tx_st_r == serial_port_pkg::ST_STOP |-> tx_out_r;
  endproperty
  a_stop_high: assert property (p_stop_high) else $error("stop bit not high"); // [R22]

  property p_status_view;
    setup && hit_txctl && !PWRITE |=> PRDATA[serial_port_pkg::TX_EMPTY] == !$past(tx_busy)
      && !PRDATA[serial_port_pkg::TX_UNUSED];
  endproperty
  a_status_view: assert property (p_status_view) else $error("transmit status wrong"); // [R6] [R20]

  property p_overrun_error_flag_sticky;
    overrun_error_flag_r && cont_rx && port_enable |=> overrun_error_flag_r;
  endproperty
  a_overrun_error_flag_sticky: assert property (p_overrun_error_flag_sticky) else $error("overrun flag dropped"); // [R14]

  property p_addr_filter;
    rx_done && !rx_keep |=> rxbuf_r == $past(rxbuf_r) && !$rose(rxbuf_full_r);
  endproperty
  a_addr_filter: assert property (p_addr_filter) else $error("data word not filtered"); // [R12]

  property p_single_clear;
    single_receive_enable_hw_clr && !wr_rxctl |=> !single_rx;
  endproperty
  a_single_clear: assert property (p_single_clear) else $error("single receive kept"); // [R10]

  property p_rx_precedence;
    port_enable && sync_rx ##1 port_enable && sync_rx |=> !rxdt_oe_r;
  endproperty
  a_rx_precedence: assert property (p_rx_precedence) else $error("data pin driven on rx"); // [R3]

  property p_apb_ready;
    setup |=> PREADY ##1 !PREADY;
  endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("ready not one cycle");

  c_async_word: cover property (rx_load && !sync);
  c_overrun: cover property (rx_over);
  c_master_tx: cover property (master && tx_load);
  c_framing: cover property (rx_load && !rx_word.stop_ok);
endmodule // serial_port_ctrl
`default_nettype wire

// ===== testbench/serial_peer.sv
// serial peer model: sends and takes asynchronous frames
`default_nettype none
module serial_peer (
  input wire logic clk,
  input wire logic line_in,
  output logic line_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // the line idles high, like a pulled-up wire
  initial line_out = 1'h1;

  // one frame; a low stop is held only past mid-bit so no false start follows
  task automatic send(input int bt, input int nb, input logic [8:0] d, input logic stop);
    int i;
    line_out <= 1'h0; // start bit
    repeat (bt) @(posedge clk);
    for (i = 0; i < nb; i++) begin
      line_out <= d[i]; // lsb first
      repeat (bt) @(posedge clk);
    end
    line_out <= stop; // stop level
    repeat (bt / 2 + 6) @(posedge clk);
    line_out <= 1'h1;
    repeat (bt + bt / 2) @(posedge clk);
  endtask

  // take one frame by sampling each bit at its middle; stop lands in w[nb]
  task automatic recv(input int bt, input int nb, output logic [9:0] w);
    int i;
    w = '0;
    @(negedge line_in);
    repeat (bt / 2) @(posedge clk);
    for (i = 0; i <= nb; i++) begin
      repeat (bt) @(posedge clk);
      w[i] = line_in; // lsb first, stop last
    end
  endtask
endmodule // serial_peer
`default_nettype wire

// ===== testbench/test_serial_port_ctrl.sv
// self-checking bench for the serial port control, status and baud logic
`default_nettype none
module test_serial_port_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst_b, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, v;
  logic txck_out, txck_oe, rxdt_out, rxdt_oe, peer_out, tx_line, rx_line;
  logic [9:0] w;
  int n_fail, checks, cyc;
  realtime t0;

  // pins resolve from the enables; undriven clock pin is pulled up
  assign tx_line = txck_oe ? txck_out : 1'h1;
  assign rx_line = rxdt_oe ? rxdt_out : peer_out;

  serial_port_ctrl DUT (.MCLK(mclk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .TXCK_PIN_IN(tx_line), .TXCK_PIN_OUT(txck_out),
    .TXCK_PIN_OE(txck_oe), .RXDT_PIN_IN(rx_line), .RXDT_PIN_OUT(rxdt_out),
    .RXDT_PIN_OE(rxdt_oe));
  serial_peer peer (.clk(mclk), .line_in(tx_line), .line_out(peer_out));

  initial begin
    mclk = 1'h0;
    forever #20 mclk = ~mclk;
  end

  // cut a hang short; the tests need well under this
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      conclude();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // apb transfer; request held until pready is seen at an edge
  // one idle edge after release so the next call never re-drives psel in that step
  task automatic xfer(input logic is_wr, input logic [7:0] a, input logic [7:0] d);
    psel <= 1'h1;
    pwrite <= is_wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge mclk);
    penable <= 1'h1;
    @(posedge mclk);
    while (pready !== 1'h1) @(posedge mclk);
    v = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge mclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'h1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'h0, a, 8'h00);
    chk(v, exp);
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    rst_b = 1'h0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    {n_fail, checks} = '0;
    repeat (6) @(posedge mclk);
    rst_b <= 1'h1;
    @(posedge mclk);
    // reset images, read-only and unused bits
    rd(serial_port_pkg::ADDR_TXCTL, 32'h02);
    rd(serial_port_pkg::ADDR_RXCTL, 32'h00);
    rd(serial_port_pkg::ADDR_BAUD, 32'h00);
    wr(serial_port_pkg::ADDR_TXCTL, 8'hFF);
    rd(serial_port_pkg::ADDR_TXCTL, 32'hF7);
    chk(txck_oe, 1'h0);
    xfer(1'h0, 8'h3C, 8'h00);
    chk({v[7:0], err}, 9'h001);
    // sync slave leaves the clock pin an input, master drives it
    wr(serial_port_pkg::ADDR_RXCTL, 8'h80);
    wr(serial_port_pkg::ADDR_TXCTL, 8'h30);
    repeat (2) @(posedge mclk);
    chk(txck_oe, 1'h0);
    wr(serial_port_pkg::ADDR_TXCTL, 8'hB0);
    repeat (2) @(posedge mclk);
    chk(txck_oe, 1'h1);
    // sync master clock period is 4(n+1) cycles
    wr(serial_port_pkg::ADDR_BAUD, 8'h01);
    wr(serial_port_pkg::ADDR_TXDATA, 8'h5A);
    @(posedge txck_out);
    t0 = $realtime;
    #1 chk(rxdt_out, 1'h0);
    @(posedge txck_out);
    #1 chk(int'(($realtime - t0) / 40.0), 32'h8);
    chk(rxdt_oe, 1'h1);
    chk(rxdt_out, 1'h1);
    repeat (80) @(posedge mclk);
    // one single receive as sync master, then hardware drops the bit
    wr(serial_port_pkg::ADDR_RXCTL, 8'hA0);
    repeat (80) @(posedge mclk);
    rd(serial_port_pkg::ADDR_RXCTL, 32'h80);
    rd(serial_port_pkg::ADDR_RXDATA, 32'hFF);
    // a receive enable in sync mode keeps the transmitter quiet
    wr(serial_port_pkg::ADDR_RXCTL, 8'h90);
    wr(serial_port_pkg::ADDR_TXDATA, 8'h5A);
    repeat (40) @(posedge mclk);
    chk(rxdt_oe, 1'h0);
    // async nine-bit transmit at 16(n+1) cycles a bit
    wr(serial_port_pkg::ADDR_RXCTL, 8'h00);
    wr(serial_port_pkg::ADDR_RXCTL, 8'h80);
    wr(serial_port_pkg::ADDR_TXCTL, 8'h65);
    fork
      peer.recv(32, 9, w);
      begin
        wr(serial_port_pkg::ADDR_TXDATA, 8'hA5);
        repeat (4) @(posedge mclk);
        rd(serial_port_pkg::ADDR_TXCTL, 32'h65);
      end
    join
    chk(w, 10'h3A5);
    repeat (40) @(posedge mclk);
    rd(serial_port_pkg::ADDR_TXCTL, 32'h67);
    // async eight-bit receive through the majority voter
    wr(serial_port_pkg::ADDR_TXCTL, 8'h04);
    wr(serial_port_pkg::ADDR_RXCTL, 8'h90);
    peer.send(32, 8, 9'h0C3, 1'h1);
    rd(serial_port_pkg::ADDR_STATUS, 32'h01);
    rd(serial_port_pkg::ADDR_RXDATA, 32'hC3);
    // second word while the first is unread overruns
    peer.send(32, 8, 9'h011, 1'h1);
    peer.send(32, 8, 9'h022, 1'h1);
    rd(serial_port_pkg::ADDR_RXCTL, 32'h92);
    wr(serial_port_pkg::ADDR_RXCTL, 8'h80);
    rd(serial_port_pkg::ADDR_RXCTL, 32'h80);
    rd(serial_port_pkg::ADDR_RXDATA, 32'h11);
    // low stop bit, then a good word clears the flag
    wr(serial_port_pkg::ADDR_RXCTL, 8'h90);
    peer.send(32, 8, 9'h0F0, 1'h0);
    rd(serial_port_pkg::ADDR_RXCTL, 32'h94);
    rd(serial_port_pkg::ADDR_RXDATA, 32'hF0);
    peer.send(32, 8, 9'h00F, 1'h1);
    rd(serial_port_pkg::ADDR_RXCTL, 32'h90);
    rd(serial_port_pkg::ADDR_RXDATA, 32'h0F);
    // address detect drops words whose ninth bit is 0
    wr(serial_port_pkg::ADDR_RXCTL, 8'hD8);
    peer.send(32, 9, 9'h055, 1'h1);
    rd(serial_port_pkg::ADDR_STATUS, 32'h00);
    peer.send(32, 9, 9'h13C, 1'h1);
    rd(serial_port_pkg::ADDR_RXCTL, 32'hD9);
    rd(serial_port_pkg::ADDR_RXDATA, 32'h3C);
    // async transmit owns its pin until the port is disabled
    wr(serial_port_pkg::ADDR_TXCTL, 8'h24);
    repeat (2) @(posedge mclk);
    chk(txck_oe, 1'h1);
    wr(serial_port_pkg::ADDR_RXCTL, 8'h00);
    repeat (2) @(posedge mclk);
    chk(txck_oe, 1'h0);
    conclude();
  end
endmodule // test_serial_port_ctrl
`default_nettype wire
